// [logic/fer_pkg.sv]
// Constants shared by the flash erase, reset and status host controller
package fer_pkg;
  // Software register offsets (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_BLOCK = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam logic [3:0] REG_ID = 4'hC;
  // Control register fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_WEN_BIT = 3;
  // Status register fields seen by software
  localparam int ST_MARK_LSB = 8;
  localparam int ST_BUSY = 16;
  localparam int ST_DONE = 17;
  localparam int ST_BAD = 18;
  localparam int ST_REFUSED = 19;
  localparam int ST_EFAIL = 20;
  localparam int ST_CHK_OK = 21;
  localparam int ID_DEV_LSB = 8;
  // Device status byte layout
  localparam int SR_FAIL = 0;
  localparam int SR_READY = 6;
  localparam int SR_WP = 7;
  localparam logic [7:0] STAT_KEEP = 8'hC1;
  // Device command codes
  localparam logic [7:0] CMD_ERASE = 8'h60;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_SIG = 8'h90;
  localparam logic [7:0] CMD_SPARE = 8'h50;
  localparam logic [7:0] CMD_MAIN = 8'h00;
  localparam logic [7:0] SIG_ADDR = 8'h00;
  localparam logic [7:0] MARK_COL = 8'h05;
  localparam logic [7:0] MARK_GOOD = 8'hFF;
  localparam logic [7:0] LAST_ADDR_MASK = 8'h03;
  localparam int BLK_LO_BITS = 3;
  localparam int BLK_LO_SHIFT = 5;
  // Timing
  localparam int CLK_NS = 25;
  localparam int T_STROBE_NS = 50;
  localparam int T_WB_NS = 100;
  localparam int STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int WB_CYC = (T_WB_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_ERASE = 3'h1,
    OP_RESET = 3'h2,
    OP_STATUS = 3'h3,
    OP_SIG = 3'h4,
    OP_CHECK = 3'h5
  } fer_op_e;
  typedef enum logic [2:0] {
    K_CMD = 3'h0,
    K_ADDR = 3'h1,
    K_WAIT = 3'h2,
    K_READ = 3'h3,
    K_END = 3'h4
  } fer_kind_e;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_FETCH = 3'h1,
    S_LOW = 3'h2,
    S_HIGH = 3'h3,
    S_WAIT = 3'h4
  } fer_state_e;
endpackage

// [logic/fer_host.sv]
// Host controller driving erase, reset, status and signature cycles
`timescale 1ns/10ps
module fer_host
  import fer_pkg::*;
#(
  parameter int BLOCK_W = 5
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic CLE,
  output logic ALE,
  output logic CE_N,
  output logic WE_N,
  output logic RE_N,
  output logic WP_N,
  input wire logic [7:0] IO_IN,
  output logic [7:0] IO_OUT,
  output logic IO_OE,
  input wire logic RB_N
);
  typedef struct packed {
    fer_state_e st;
    fer_op_e op;
    logic [3:0] step;
    logic [3:0] ph;
    logic rdi;
    logic cle, ale, we_n, re_n, ce_n, io_oe;
    logic [7:0] io_out;
    logic wen;
    logic [BLOCK_W-1:0] blk;
    logic [7:0] stat, mark, id0, id1;
    logic done, bad, refused, efail, chk_ok, saw_stat;
    logic [BLOCK_W-1:0] chk_blk;
    logic [31:0] rdata;
  } fer_regs_s;

  localparam fer_regs_s RESET_S = '{st: S_IDLE, op: OP_NONE, we_n: 1'b1,
    re_n: 1'b1, ce_n: 1'b1, default: '0};
  localparam logic [3:0] STROBE_END = 4'(STROBE_CYC - 1);
  localparam logic [3:0] WB_END = 4'(WB_CYC);

  fer_regs_s r, n;
  logic [10:0] item;
  logic [7:0] row_lo, row_hi;
  fer_op_e wr_op;

  // One step of the per-operation bus script: {kind, byte}
  function automatic logic [10:0] seq_item(fer_op_e op, logic [3:0] step,
                                           logic [7:0] a1, logic [7:0] a2);
    logic [10:0] it;
    it = {K_END, 8'h00};
    case (op)
      OP_ERASE: begin
        case (step)
          4'h0: it = {K_CMD, CMD_ERASE};
          4'h1: it = {K_ADDR, a1};
          4'h2: it = {K_ADDR, a2};
          4'h3: it = {K_CMD, CMD_CONFIRM};
          4'h4: it = {K_WAIT, 8'h00};
          4'h5: it = {K_CMD, CMD_STATUS};
          4'h6: it = {K_READ, 8'h00};
          default: it = {K_END, 8'h00};
        endcase
      end
      OP_RESET: begin
        case (step)
          4'h0: it = {K_CMD, CMD_RESET};
          4'h1: it = {K_WAIT, 8'h00};
          default: it = {K_END, 8'h00};
        endcase
      end
      OP_STATUS: begin
        case (step)
          4'h0: it = {K_CMD, CMD_STATUS};
          4'h1: it = {K_READ, 8'h00};
          default: it = {K_END, 8'h00};
        endcase
      end
      OP_SIG: begin
        case (step)
          4'h0: it = {K_CMD, CMD_SIG};
          4'h1: it = {K_ADDR, SIG_ADDR};
          4'h2: it = {K_WAIT, 8'h00};
          4'h3: it = {K_READ, 8'h00};
          4'h4: it = {K_READ, 8'h00};
          default: it = {K_END, 8'h00};
        endcase
      end
      // fresh pointer command ends the marker read
      OP_CHECK: begin
        case (step)
          4'h0: it = {K_CMD, CMD_SPARE};
          4'h1: it = {K_ADDR, MARK_COL};
          4'h2: it = {K_ADDR, a1};
          4'h3: it = {K_ADDR, a2};
          4'h4: it = {K_WAIT, 8'h00};
          4'h5: it = {K_READ, 8'h00};
          4'h6: it = {K_CMD, CMD_MAIN};
          default: it = {K_END, 8'h00};
        endcase
      end
      default: it = {K_END, 8'h00};
    endcase
    return it;
  endfunction

  // Row bytes of page zero of the selected block
  // upper data lines forced low in last address cycle
  assign row_lo = 8'({r.blk[BLK_LO_BITS-1:0], 5'h00});
  assign row_hi = 8'(r.blk >> BLK_LO_BITS) & LAST_ADDR_MASK;
  assign item = seq_item(r.op, r.step, row_lo, row_hi);
  assign wr_op = fer_op_e'(WDATA[CTRL_OP_LSB +: 3]);

  // Sequencer and software register file
  always_comb begin
    n = r;
    n.rdata = 32'h0000_0000;
    case (r.st)
      S_IDLE: begin
        n.ce_n = 1'b1;
      end
      S_FETCH: begin
        n.ph = 4'h0;
        case (fer_kind_e'(item[10:8]))
          K_CMD, K_ADDR: begin
            n.cle = (fer_kind_e'(item[10:8]) == K_CMD);
            n.ale = (fer_kind_e'(item[10:8]) == K_ADDR);
            n.io_out = item[7:0];
            n.io_oe = 1'b1;
            n.we_n = 1'b0;
            n.st = S_LOW;
          end
          K_READ: begin
            n.re_n = 1'b0;
            n.st = S_LOW;
          end
          K_WAIT: n.st = S_WAIT;
          default: begin
            n.st = S_IDLE;
            n.ce_n = 1'b1;
            n.done = 1'b1;
            // marker other than FFh marks a bad block
            if (r.op == OP_CHECK) begin
              n.bad = (r.mark != MARK_GOOD);
              n.chk_ok = (r.mark == MARK_GOOD);
              n.chk_blk = r.blk;
            end
            // erase failure kept for block replacement
            if (r.op == OP_ERASE) begin
              n.efail = r.stat[SR_FAIL];
            end
          end
        endcase
      end
      S_LOW: begin
        n.ph = r.ph + 4'h1;
        if (r.ph == STROBE_END) begin
          // Sample on the last low cycle, before the strobe rises
          if (!r.re_n) begin
            case (r.op)
              OP_SIG: begin
                if (r.rdi) n.id1 = IO_IN;
                else n.id0 = IO_IN;
                n.rdi = 1'b1;
              end
              OP_CHECK: n.mark = IO_IN;
              default: n.stat = IO_IN & STAT_KEEP;
            endcase
          end
          if (r.cle && r.io_out == CMD_STATUS) n.saw_stat = 1'b1;
          n.we_n = 1'b1;
          n.re_n = 1'b1;
          n.ph = 4'h0;
          n.st = S_HIGH;
        end
      end
      S_HIGH: begin
        n.ph = r.ph + 4'h1;
        if (r.ph == STROBE_END) begin
          n.cle = 1'b0;
          n.ale = 1'b0;
          n.io_oe = 1'b0;
          n.step = r.step + 4'h1;
          n.st = S_FETCH;
        end
      end
      // busy wait then status read closes every erase
      S_WAIT: begin
        if (r.ph != WB_END) n.ph = r.ph + 4'h1;
        else if (RB_N) begin
          n.step = r.step + 4'h1;
          n.st = S_FETCH;
        end
      end
      default: n.st = S_IDLE;
    endcase
    // Software writes
    if (WR && ADDR == REG_BLOCK) n.blk = WDATA[BLOCK_W-1:0];
    if (WR && ADDR == REG_CTRL) begin
      n.wen = WDATA[CTRL_WEN_BIT];
      if (wr_op != OP_NONE) begin
        // erase only a block whose marker was read good
        if (r.st != S_IDLE || (wr_op == OP_ERASE && !(r.chk_ok &&
            r.chk_blk == r.blk && WDATA[CTRL_WEN_BIT]))) begin
          n.refused = 1'b1;
        end else begin
          n.op = wr_op;
          n.step = 4'h0;
          n.rdi = 1'b0;
          n.st = S_FETCH;
          n.ce_n = 1'b0;
          n.done = 1'b0;
          n.refused = 1'b0;
          n.saw_stat = 1'b0;
          if (wr_op == OP_CHECK) n.chk_ok = 1'b0;
        end
      end
    end
    // Software reads, answered one cycle later
    if (RD) begin
      case (ADDR)
        REG_CTRL: n.rdata = 32'({r.wen, r.op});
        REG_BLOCK: n.rdata = 32'(r.blk);
        REG_STAT: begin
          n.rdata[7:0] = r.stat;
          n.rdata[ST_MARK_LSB +: 8] = r.mark;
          n.rdata[ST_BUSY] = (r.st != S_IDLE);
          n.rdata[ST_DONE] = r.done;
          n.rdata[ST_BAD] = r.bad;
          n.rdata[ST_REFUSED] = r.refused;
          n.rdata[ST_EFAIL] = r.efail;
          n.rdata[ST_CHK_OK] = r.chk_ok;
        end
        REG_ID: begin
          n.rdata[7:0] = r.id0;
          n.rdata[ID_DEV_LSB +: 8] = r.id1;
        end
        default: n.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register, synchronous reset
  always_ff @(posedge SYS_CLK) begin
    if (RST) r <= RESET_S;
    else r <= n;
  end

  assign RDATA = r.rdata;
  assign CLE = r.cle;
  assign ALE = r.ale;
  assign CE_N = r.ce_n;
  assign WE_N = r.we_n;
  assign RE_N = r.re_n;
  assign WP_N = r.wen;
  assign IO_OUT = r.io_out;
  assign IO_OE = r.io_oe;

  // Latch edges of command and address cycles, for checking
  logic cmd_wr, addr_wr, fin;
  assign cmd_wr = r.st == S_HIGH && r.ph == 4'h0 && r.cle;
  assign addr_wr = r.st == S_HIGH && r.ph == 4'h0 && r.ale;
  assign fin = r.st == S_FETCH && fer_kind_e'(item[10:8]) == K_END;

  sequence s_addr;
    ##[1:20] addr_wr;
  endsequence
  property p_erase_seq;
    @(posedge SYS_CLK) disable iff (RST)
    cmd_wr && r.io_out == CMD_ERASE |-> s_addr ##0 s_addr
      ##[1:20] (cmd_wr && r.io_out == CMD_CONFIRM);
  endproperty
  a_erase_seq: assert property (p_erase_seq) else $error("bad erase order");
  property p_last_addr;
    @(posedge SYS_CLK) disable iff (RST)
    addr_wr && r.op == OP_ERASE && r.step == 4'h2 |-> r.io_out[7:2] == 6'h00;
  endproperty
  a_last_addr: assert property (p_last_addr) else $error("high lines set");
  property p_stat_after;
    @(posedge SYS_CLK) disable iff (RST)
    fin && r.op == OP_ERASE |-> r.saw_stat;
  endproperty
  a_stat_after: assert property (p_stat_after) else $error("no status");
  property p_reserved;
    @(posedge SYS_CLK) disable iff (RST)
    $changed(r.stat) |-> r.stat[5:1] == 5'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved kept");
  property p_sig;
    @(posedge SYS_CLK) disable iff (RST)
    cmd_wr && r.io_out == CMD_SIG |-> ##[1:20] (addr_wr && r.io_out == SIG_ADDR);
  endproperty
  a_sig: assert property (p_sig) else $error("signature address wrong");
  property p_bad;
    @(posedge SYS_CLK) disable iff (RST)
    fin && r.op == OP_CHECK |=> r.done && r.bad == ($past(r.mark) != MARK_GOOD);
  endproperty
  a_bad: assert property (p_bad) else $error("bad flag wrong");
  property p_chk_first;
    @(posedge SYS_CLK) disable iff (RST)
    cmd_wr && r.io_out == CMD_ERASE |-> r.chk_ok && r.chk_blk == r.blk;
  endproperty
  a_chk_first: assert property (p_chk_first) else $error("unchecked erase");
  property p_efail;
    @(posedge SYS_CLK) disable iff (RST)
    fin && r.op == OP_ERASE |=> r.efail == $past(r.stat[SR_FAIL]);
  endproperty
  a_efail: assert property (p_efail) else $error("erase fail lost");
endmodule

// [bench/fer_flash_model.sv]
// Behavioural flash device answering erase, reset, status and signature
`timescale 1ns/10ps
module fer_flash_model
  import fer_pkg::*;
#(
  parameter int BAD_BLK = 6,
  parameter int FAIL_BLK = 9,
  parameter int BUSY_NS = 2000,
  parameter logic [7:0] MAKER = 8'h5A, // Arbitrary value
  parameter logic [7:0] DEVICE = 8'hC3 // Arbitrary value
) (
  input wire logic CLE,
  input wire logic ALE,
  input wire logic CE_N,
  input wire logic WE_N,
  input wire logic RE_N,
  input wire logic WP_N,
  input wire logic [7:0] DIN,
  output logic [7:0] DOUT,
  output logic DOE,
  output logic RB_N
);
  logic [7:0] cmd = 8'h00, q = 8'h00;
  logic [7:0] a [4];
  logic busy = 1'b0, fail = 1'b0, in_rst = 1'b0, spare = 1'b0;
  logic [31:0] erased = 32'h0;
  logic [1:0] rmode = 2'h0;
  logic [4:0] blk = 5'h0;
  int acnt = 0, rcnt = 0, viol = 0, rst_cnt = 0, rstd = 0;

  // Open-drain busy, low while an erase, reset or spare page load runs
  assign RB_N = !busy;
  assign DOUT = (rmode == 2'h1) ? {WP_N, !busy, 5'h16, fail} : q;
  initial DOE = 1'b0;

  // Commands and addresses latch on the rising write strobe
  always @(posedge WE_N) begin
    if (!CE_N && CLE) begin
      // Only status and reset are heard while busy
      if (!busy || DIN == CMD_STATUS || DIN == CMD_RESET) begin
        if (DIN == CMD_RESET) begin
          // Clear and recover unless already reset
          if (!in_rst) begin
            if (busy && cmd == CMD_ERASE) erased[blk] = 1'b0;
            rstd = busy ? 400 : 100;
            fail = 1'b0;
            rmode = 2'h0;
            spare = 1'b0;
            in_rst = 1'b1;
            rst_cnt++;
            busy = 1'b1;
            busy <= #(rstd) 1'b0;
          end
        end else begin
          // Two row cycles, block from upper bits only
          if (DIN == CMD_CONFIRM && cmd == CMD_ERASE) begin
            if (acnt != 2 || a[1][7:2] != 6'h0) viol++;
            blk = {a[1][1:0], a[0][7:5]};
            // Whole block to ones unless protected
            if (WP_N) begin
              erased[blk] = 1'b1;
              fail = (blk == FAIL_BLK);
              busy = 1'b1;
              busy <= #(BUSY_NS) 1'b0;
            end
          end
          in_rst = 1'b0;
          cmd = DIN;
          acnt = 0;
          rcnt = 0;
          rmode = (DIN == CMD_STATUS) ? 2'h1 : 2'h0;
          if (DIN == CMD_SPARE) spare = 1'b1;
          if (DIN == CMD_MAIN) spare = 1'b0;
        end
      end
    end else if (!CE_N && ALE) begin
      if (acnt < 4) a[acnt] = DIN;
      acnt++;
      if (cmd == CMD_SIG) begin
        if (DIN != SIG_ADDR) viol++;
        rmode = 2'h2;
      end
      // Spare page load after column and two row cycles
      if (cmd == CMD_SPARE && acnt == 3) begin
        blk = {a[2][1:0], a[1][7:5]};
        rmode = 2'h3;
        busy = 1'b1;
        busy <= #200 1'b0;
      end
    end
  end

  // Data out on the falling read strobe
  always @(negedge RE_N) begin
    if (!CE_N) begin
      DOE = 1'b1;
      // Maker then device code, each later read returns the previous byte inverted
      if (rmode == 2'h2) q = (rcnt == 0) ? MAKER : (rcnt == 1) ? DEVICE : ~q;
      if (rmode == 2'h3) q = (blk == BAD_BLK) ? 8'h00 : MARK_GOOD;
      rcnt++;
    end
  end

  // Bus released once the read strobe rises
  always @(posedge RE_N) DOE = 1'b0;
endmodule

// [bench/fer_host_tb.sv]
// Self-checking bench for the flash erase, reset and status host
`timescale 1ns/10ps
module fer_host_tb
  import fer_pkg::*;
();
  localparam int BAD = 6;
  localparam int FAILB = 9;
  localparam logic [7:0] MK = 8'h5A; // Arbitrary maker value
  localparam logic [7:0] DV = 8'hC3; // Arbitrary device value
  logic sys_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, s, exp_st, erased_exp = 32'h0;
  logic cle, ale, ce_n, we_n, re_n, wp_n, io_oe, rb_n, fm_oe;
  logic [7:0] io_in, io_out, fm_dout;
  logic [63:0] e;
  logic [63:0] exp_q [$];
  int bad_count = 0, checks_done = 0, b, i;
  int blocks [3] = '{3, BAD, FAILB};

  always #12.5 sys_clk = ~sys_clk;
  // Whoever drives wins; an idle bus shows the inverse, not a held value
  assign io_in = fm_oe ? fm_dout : (io_oe ? io_out : ~io_out);

  fer_host DUT (.SYS_CLK(sys_clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .CLE(cle), .ALE(ale), .CE_N(ce_n),
    .WE_N(we_n), .RE_N(re_n), .WP_N(wp_n), .IO_IN(io_in),
    .IO_OUT(io_out), .IO_OE(io_oe), .RB_N(rb_n));
  fer_flash_model #(.BAD_BLK(BAD), .FAIL_BLK(FAILB), .MAKER(MK),
    .DEVICE(DV)) FM (.CLE(cle), .ALE(ale), .CE_N(ce_n), .WE_N(we_n),
    .RE_N(re_n), .WP_N(wp_n), .DIN(io_out), .DOUT(fm_dout), .DOE(fm_oe),
    .RB_N(rb_n));

  task automatic results();
    if (bad_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  // A zero mask notes a read whose value nobody compares
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] x,
                        input logic [31:0] m);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back({m, x});
    @(posedge sys_clk);
    rd <= 1'b0;
  endtask

  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      bad_count++;
      $display("FAIL %0t model state %h expected %h", $time, g, x);
    end
  endtask

  // Start an operation, then poll status under a bounded count
  task automatic run(input logic [31:0] c);
    wr_reg(REG_CTRL, c);
    for (i = 0; i < 300; i++) begin
      rd_reg(REG_STAT, 32'h0, 32'h0);
      #1;
      s = rdata;
      if (s[ST_DONE] === 1'b1 && s[ST_BUSY] === 1'b0) break;
    end
    if (i == 300) begin
      bad_count++;
      $display("FAIL %0t operation never finished", $time);
    end
  endtask

  // Read data stand one cycle after the strobe; compare with oldest note
  always @(posedge sys_clk) begin
    rd_d <= rd;
    if (rd_d === 1'b1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[63:32] != 32'h0) begin
        checks_done++;
        if ((rdata & e[63:32]) !== e[31:0]) begin
          bad_count++;
          $display("FAIL %0t read %h expected %h", $time, rdata, e[31:0]);
        end
      end
    end
  end

  initial begin
    void'($urandom(32'h167D302E));
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    cmp({cle, ale, ce_n, we_n, re_n, wp_n, io_oe}, 32'h1C);
    rd_reg(REG_STAT, 32'h0, 32'h003F00FF);
    rd_reg(REG_CTRL, 32'h0, 32'hF);
    rd_reg(4'h2, 32'h0, 32'hFFFFFFFF);
    run({29'h0, OP_SIG});
    rd_reg(REG_ID, {16'h0, DV, MK}, 32'hFFFF);
    run({28'h0, 1'b0, OP_STATUS});
    rd_reg(REG_STAT, 32'h00020040, 32'h000300FF);
    run({28'h0, 1'b1, OP_STATUS});
    rd_reg(REG_STAT, 32'h000200C0, 32'h000300FF);
    // Erase before any marker was collected is turned away
    wr_reg(REG_BLOCK, 32'h3);
    wr_reg(REG_CTRL, {28'h0, 1'b1, OP_ERASE});
    rd_reg(REG_STAT, 32'h000A0000, 32'h000B0000);
    // Good, bad, failing and one random block; reset in between
    for (int k = 0; k < 4; k++) begin
      if (k == 3) begin
        run({28'h0, 1'b1, OP_RESET});
        run({28'h0, 1'b1, OP_RESET});
        cmp(FM.rst_cnt, 32'h1);
        run({28'h0, 1'b1, OP_STATUS});
        rd_reg(REG_STAT, 32'h000200C0, 32'h000300FF);
      end
      b = (k < 3) ? blocks[k] : 10 + $urandom % 20;
      wr_reg(REG_BLOCK, b);
      run({28'h0, 1'b1, OP_CHECK});
      exp_st = (b == BAD) ? 32'h00060000 : 32'h0022FF00;
      rd_reg(REG_STAT, exp_st, 32'h0026FF00);
      if (b == BAD) begin
        wr_reg(REG_CTRL, {28'h0, 1'b1, OP_ERASE});
        rd_reg(REG_STAT, 32'h00080000, 32'h00080000);
      end else begin
        run({28'h0, 1'b1, OP_ERASE});
        erased_exp[b] = 1'b1;
        exp_st = (b == FAILB) ? 32'h001000C1 : 32'h000000C0;
        rd_reg(REG_STAT, exp_st, 32'h001800FF);
      end
    end
    cmp(FM.viol, 32'h0);
    cmp(FM.erased, erased_exp);
    results();
  end

  // Cut a hang short far beyond the expected run length
  initial begin
    #400000;
    bad_count++;
    $display("FAIL %0t watchdog expired", $time);
    results();
  end
endmodule
